// ===== pms_pkg.sv
// Purpose: shared constants and types for the phase mode selector
// Assumes: one 100 MHz clock, registers on a plain strobe port
// Notes: all offsets are byte addresses of 32-bit words
package pms_pkg;
    // -----------------------------------------------------------
    // clock and timing
    // -----------------------------------------------------------
    localparam int CLK_MHZ = 100;           // system clock rate
    localparam int DIODE_TARGET_NS = 40;    // body diode aim
    // nearest whole cycle count for the diode aim
    localparam int DIODE_TARGET_CYC = (DIODE_TARGET_NS * CLK_MHZ + 500) / 1000;
    localparam int OC_THRESHOLD_MV = 1500;  // fixed for all configs
    localparam int SLEW_DIV_DEF = 100;      // clocks per code step

    // -----------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------
    localparam logic [7:0] OFS_CORE_CODE = 8'h00; // core voltage code
    localparam logic [7:0] OFS_AUX_CODE = 8'h04;  // aux voltage code
    localparam logic [7:0] OFS_STATE = 8'h08;     // live mode state
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;  // sticky events
    localparam logic [7:0] OFS_IRQ_CLR = 8'h10;   // write one to clear
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;    // interrupt enable
    localparam logic [7:0] OFS_ZC_THR = 8'h18;    // zero-cross codes

    // -----------------------------------------------------------
    // field layout and reset values
    // -----------------------------------------------------------
    localparam int CODE_W = 8;               // voltage code width
    localparam int THR_W = 6;                // zero-cross threshold width
    localparam int EVT_W = 6;                // event bits
    localparam int EVT_OC = 0;               // bits 1:0 overcurrent
    localparam int EVT_MODE = 2;             // bits 3:2 mode change
    localparam int EVT_RAMP = 4;             // bits 5:4 ramp done
    localparam logic [7:0] CODE_RST = 8'h00; // codes at reset
    localparam logic [5:0] THR_RST = 6'h20;  // threshold midscale
    localparam logic [5:0] EVT_RST = 6'h00;  // status and enable

    // -----------------------------------------------------------
    // types
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        PMS_OFF, PMS_ONE, PMS_TWO, PMS_THREE
    } pms_phases_e;

    typedef struct packed {
        pms_phases_e phases;    // active phase count
        logic diode_emulation;  // 1: single-phase diode emulation
    } pms_mode_s;

    typedef struct packed {
        logic core_phase3_sense; // strap high on third core sense
        logic core_phase2_sense; // strap high on second core sense
        logic core_phase1_sense; // strap high on first core sense
        logic aux_phase2_sense;  // strap high on second aux sense
        logic aux_phase1_sense;  // strap high on first aux sense
        logic power_state_bit1_n;
        logic power_state_bit0_n;
    } pms_strap_s;
endpackage : pms_pkg

// ===== pms_phase_mode_selector.sv
// Purpose: phase count and conduction mode selection, two outputs
// Assumes: all pin inputs are asynchronous and get synchronised
// Notes: index 0 is the core output, index 1 the auxiliary output
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
module pms_phase_mode_selector #(
    parameter int SLEW_DIV = pms_pkg::SLEW_DIV_DEF // clocks per step
) (
    input wire logic clock, // 100 MHz
    input wire logic rst, // async, high
    input wire pms_pkg::pms_strap_s strap_pins, // straps, state bits
    input wire logic [1:0] over_threshold, // monitor > limit
    input wire logic [1:0] cycle_start, // switching edge
    input wire logic [1:0] lowside_off, // low side released
    input wire logic [1:0] diode_conducting, // phase node negative
    input wire logic [7:0] reg_addr, // byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_write, // write strobe
    input wire logic reg_read, // read strobe
    output logic [31:0] reg_rdata, // one cycle later
    output pms_pkg::pms_mode_s core_mode, // applied core mode
    output pms_pkg::pms_mode_s aux_mode, // applied aux mode
    output logic [1:0] overcurrent, // oc flags
    output logic [7:0] core_dac_code, // core reference
    output logic [7:0] aux_dac_code, // aux reference
    output logic [1:0] decaying, // falling freely
    output logic fb_switch_close, // join feedbacks
    output logic fb2_track, // drive node 2
    output logic [5:0] core_zc_threshold, // comparator code
    output logic [5:0] aux_zc_threshold, // comparator code
    output logic irq // level interrupt
);
    // -----------------------------------------------------------
    // declarations
    // -----------------------------------------------------------
    localparam int NPIN = 15; // synchronised bits
    localparam logic [3:0] DIODE_AIM = 4'(pms_pkg::DIODE_TARGET_CYC);
    localparam logic [3:0] DCNT_MAX = 4'hF; // counter saturates
    localparam logic [5:0] THR_MAX = 6'h3F; // top threshold
    localparam logic [5:0] THR_MIN = 6'h00; // bottom threshold

    logic [NPIN-1:0] sync_a; // first stage only
    logic [NPIN-1:0] sync_b; // usable stage
    pms_pkg::pms_strap_s strap; // synced straps
    logic [1:0] oc_sync; // synced oc
    logic [1:0] cyc_sync; // synced cycle level
    logic [1:0] off_sync; // synced low side off
    logic [1:0] dio_sync; // synced diode level
    logic [1:0] cyc_prev; // edge detect
    logic [1:0] off_prev; // edge detect
    logic [1:0] cyc_edge; // boundary pulse
    logic [1:0] off_edge; // turn-off pulse

    pms_pkg::pms_mode_s want [2]; // decoded modes
    pms_pkg::pms_mode_s mode [2]; // applied modes
    logic core_two_cfg; // two-phase strap

    logic [7:0] target [2]; // software code
    logic [7:0] dac [2]; // reference code
    logic [15:0] slew_cnt; // divider
    logic slew_tick; // one-cycle step

    logic [3:0] dcnt [2]; // diode cycles
    logic [1:0] dmeas; // measuring
    logic [5:0] thr [2]; // comparator codes

    logic [5:0] evt_set; // event pulses
    logic [5:0] irq_stat; // sticky status
    logic [5:0] irq_en; // enable mask
    logic [1:0] oc_prev; // oc edge detect
    logic [1:0] ramping; // ramp in progress

    // -----------------------------------------------------------
    // decode functions
    // -----------------------------------------------------------
    // core: straps pick the configuration, power state bits shed
    function automatic pms_pkg::pms_mode_s decode_core(
        input pms_pkg::pms_strap_s s
    );
        pms_pkg::pms_mode_s m;
        logic both_low;
        logic bit0_low;
        m.phases = pms_pkg::PMS_THREE;
        m.diode_emulation = 1'b0;
        both_low = !s.power_state_bit0_n && !s.power_state_bit1_n;
        bit0_low = !s.power_state_bit0_n;
        if (s.core_phase1_sense) begin
            m.phases = pms_pkg::PMS_OFF;
        end else if (both_low) begin
            m.phases = pms_pkg::PMS_ONE;
            m.diode_emulation = 1'b1;
        end else if (s.core_phase3_sense && s.core_phase2_sense) begin
            m.phases = pms_pkg::PMS_ONE;
        end else if (s.core_phase3_sense) begin
            // two-phase config sheds phase two on bit0 low
            m.phases = bit0_low ? pms_pkg::PMS_ONE : pms_pkg::PMS_TWO;
        end else begin
            // code 01 is undefined; treated like 11
            m.phases = bit0_low ? pms_pkg::PMS_TWO : pms_pkg::PMS_THREE;
        end
        return m;
    endfunction : decode_core

    // aux: second sense strap picks one or two phases
    function automatic pms_pkg::pms_mode_s decode_aux(
        input pms_pkg::pms_strap_s s
    );
        pms_pkg::pms_mode_s m;
        m.phases = pms_pkg::PMS_TWO;
        m.diode_emulation = 1'b0;
        if (s.aux_phase1_sense) begin
            m.phases = pms_pkg::PMS_OFF;
        end else if (!s.power_state_bit0_n && !s.power_state_bit1_n) begin
            m.phases = pms_pkg::PMS_ONE;
            m.diode_emulation = 1'b1;
        end else if (s.aux_phase2_sense || !s.power_state_bit0_n) begin
            m.phases = pms_pkg::PMS_ONE;
        end else begin
            m.phases = pms_pkg::PMS_TWO;
        end
        return m;
    endfunction : decode_aux

    // saturating step of a threshold code
    function automatic logic [5:0] step_thr(
        input logic [5:0] t,
        input logic up
    );
        logic [5:0] r;
        r = t;
        if (up && t != THR_MAX) begin
            r = t + 6'h01;
        end else if (!up && t != THR_MIN) begin
            r = t - 6'h01;
        end
        return r;
    endfunction : step_thr

    // -----------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------
    // two flops on every pin before any logic looks at it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {strap_pins, over_threshold, cycle_start,
                       lowside_off, diode_conducting};
            sync_b <= sync_a;
        end
    end

    assign strap = sync_b[14:8];
    assign oc_sync = sync_b[7:6];
    assign cyc_sync = sync_b[5:4];
    assign off_sync = sync_b[3:2];
    assign dio_sync = sync_b[1:0];

    // edge detectors read the second stage only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc_prev <= '0;
            off_prev <= '0;
            oc_prev <= '0;
        end else begin
            cyc_prev <= cyc_sync;
            off_prev <= off_sync;
            oc_prev <= oc_sync;
        end
    end

    assign cyc_edge = cyc_sync & ~cyc_prev;
    assign off_edge = off_sync & ~off_prev;

    // -----------------------------------------------------------
    // mode selection
    // -----------------------------------------------------------
    assign want[0] = decode_core(strap);
    assign want[1] = decode_aux(strap);

    // boundary-only changes keep pulses whole; disable acts at once
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode[0] <= '{phases: pms_pkg::PMS_OFF, diode_emulation: 1'b0};
            mode[1] <= '{phases: pms_pkg::PMS_OFF, diode_emulation: 1'b0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cyc_edge[i] || want[i].phases == pms_pkg::PMS_OFF) begin
                    mode[i] <= want[i];
                end
            end
        end
    end

    assign core_mode = mode[0];
    assign aux_mode = mode[1];

    // second feedback only exists in the two-phase core strap
    assign core_two_cfg = strap.core_phase3_sense && !strap.core_phase2_sense
                          && !strap.core_phase1_sense;

    // switch output is a flop so it never glitches on decode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fb_switch_close <= 1'b0;
            fb2_track <= 1'b0;
        end else begin
            fb_switch_close <= core_two_cfg
                && mode[0].phases == pms_pkg::PMS_TWO;
            // node two follows main while the switch is open
            fb2_track <= core_two_cfg
                && mode[0].phases != pms_pkg::PMS_TWO;
        end
    end

    // -----------------------------------------------------------
    // overcurrent
    // -----------------------------------------------------------
    // one fixed comparator limit, never scaled by phase count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overcurrent <= '0;
        end else begin
            overcurrent <= oc_sync;
        end
    end

    // -----------------------------------------------------------
    // voltage code slewing
    // -----------------------------------------------------------
    // divider producing the slew step enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slew_cnt <= '0;
            slew_tick <= 1'b0;
        end else if (slew_cnt == 16'(SLEW_DIV - 1)) begin
            slew_cnt <= '0;
            slew_tick <= 1'b1;
        end else begin
            slew_cnt <= slew_cnt + 16'h0001;
            slew_tick <= 1'b0;
        end
    end

    // up steps are paced; down jumps and the load sets the fall
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac[0] <= pms_pkg::CODE_RST;
            dac[1] <= pms_pkg::CODE_RST;
            decaying <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (target[i] < dac[i]) begin
                    dac[i] <= target[i];
                    decaying[i] <= 1'b1;
                end else if (target[i] > dac[i]) begin
                    decaying[i] <= 1'b0;
                    if (slew_tick) begin
                        dac[i] <= dac[i] + 8'h01;
                    end
                end else begin
                    decaying[i] <= 1'b0;
                end
            end
        end
    end

    assign core_dac_code = dac[0];
    assign aux_dac_code = dac[1];

    // -----------------------------------------------------------
    // adaptive zero-cross threshold
    // -----------------------------------------------------------
    // long diode time means turn-off came too early: lower the code
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dcnt[0] <= '0;
            dcnt[1] <= '0;
            dmeas <= '0;
            thr[0] <= pms_pkg::THR_RST;
            thr[1] <= pms_pkg::THR_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!mode[i].diode_emulation) begin
                    dmeas[i] <= 1'b0;                       // idle outside diode emulation
                    dcnt[i] <= '0;
                end else if (off_edge[i]) begin
                    dmeas[i] <= 1'b1;
                    dcnt[i] <= {3'b000, dio_sync[i]}; // diode may be on already
                end else if (dmeas[i] && dio_sync[i] && dcnt[i] != DCNT_MAX) begin
                    dcnt[i] <= dcnt[i] + 4'h1;
                end else if (dmeas[i]) begin
                    dmeas[i] <= 1'b0;
                    if (dcnt[i] > DIODE_AIM) begin
                        thr[i] <= step_thr(thr[i], 1'b0);
                    end else if (dcnt[i] < DIODE_AIM) begin
                        thr[i] <= step_thr(thr[i], 1'b1);
                    end
                end
            end
        end
    end

    assign core_zc_threshold = thr[0];
    assign aux_zc_threshold = thr[1];

    // -----------------------------------------------------------
    // events and interrupt
    // -----------------------------------------------------------
    always_comb begin
        evt_set = '0;
        for (int i = 0; i < 2; i++) begin
            evt_set[pms_pkg::EVT_OC + i] = oc_sync[i] && !oc_prev[i];
            evt_set[pms_pkg::EVT_MODE + i] = mode[i] != want[i] && cyc_edge[i];
            evt_set[pms_pkg::EVT_RAMP + i] = ramping[i] && target[i] == dac[i];
        end
    end

    // ramp marker so ramp done fires once per upward move
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ramping <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ramping[i] <= target[i] > dac[i];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_stat <= pms_pkg::EVT_RST;
        end else if (reg_write && reg_addr == pms_pkg::OFS_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~reg_wdata[5:0]) | evt_set;
        end else begin
            irq_stat <= irq_stat | evt_set;
        end
    end

    assign irq = |(irq_stat & irq_en);

    // -----------------------------------------------------------
    // register port
    // -----------------------------------------------------------
    // writable registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            target[0] <= pms_pkg::CODE_RST;
            target[1] <= pms_pkg::CODE_RST;
            irq_en <= pms_pkg::EVT_RST;
        end else if (reg_write) begin
            case (reg_addr)
                pms_pkg::OFS_CORE_CODE: target[0] <= reg_wdata[7:0];
                pms_pkg::OFS_AUX_CODE: target[1] <= reg_wdata[7:0];
                pms_pkg::OFS_IRQ_EN: irq_en <= reg_wdata[5:0];
                default: ; // read-only or unmapped: ignored
            endcase
        end
    end

    // read data appear the cycle after the strobe, zero otherwise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                pms_pkg::OFS_CORE_CODE: reg_rdata <= {24'h00_0000, target[0]};
                pms_pkg::OFS_AUX_CODE: reg_rdata <= {24'h00_0000, target[1]};
                pms_pkg::OFS_STATE: reg_rdata <= {5'h00, dac[1], dac[0],
                    fb_switch_close, overcurrent, decaying, mode[1], mode[0]};
                pms_pkg::OFS_IRQ_STAT: reg_rdata <= {26'h000_0000, irq_stat};
                pms_pkg::OFS_IRQ_EN: reg_rdata <= {26'h000_0000, irq_en};
                pms_pkg::OFS_ZC_THR: reg_rdata <= {20'h0_0000, thr[1], thr[0]};
                default: reg_rdata <= '0; // unmapped and clear register
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : pms_phase_mode_selector

// ===== pms_phase_mode_selector_properties.sv
// Purpose: port-level properties of the phase mode selector
// Assumes: bound onto the top module, one clock domain
// Notes: pins pass two sync stages before any mode moves
`timescale 1ns/100ps
module pms_phase_mode_selector_properties (
    input wire logic clock,                    // clock
    input wire logic rst,                      // async reset
    input wire logic [1:0] over_threshold,     // comparator levels
    input wire logic [1:0] cycle_start,        // boundary pulses
    input wire pms_pkg::pms_mode_s core_mode,  // applied core mode
    input wire pms_pkg::pms_mode_s aux_mode,   // applied aux mode
    input wire logic [1:0] overcurrent,        // oc flags
    input wire logic [7:0] core_dac_code,      // core reference
    input wire logic fb_switch_close,          // feedback switch
    input wire logic fb2_track,                // node 2 tracking
    input wire logic [5:0] core_zc_threshold   // comparator code
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    // --------------------------------------------------------
    // boundary history: the core mode may only move after an edge, except into off
    // --------------------------------------------------------
    logic [7:0] cs_hist; // recent core boundary samples
    always_ff @(posedge clock or posedge rst) begin
        if (rst) cs_hist <= 8'h00;
        else cs_hist <= {cs_hist[6:0], cycle_start[0]};
    end
    AST_FB_EXCL: assert property (!(fb_switch_close && fb2_track))
        else $error("switch closed while node 2 tracks");
    AST_FB_TWO: assert property (fb_switch_close |-> core_mode.phases == pms_pkg::PMS_TWO
        || $past(core_mode.phases) == pms_pkg::PMS_TWO)
        else $error("switch closed outside two-phase mode");
    AST_FB2_OPEN: assert property (fb2_track |-> core_mode.phases != pms_pkg::PMS_TWO
        || $past(core_mode.phases) != pms_pkg::PMS_TWO)
        else $error("node 2 tracking in two-phase mode");
    AST_DE_ONE: assert property (core_mode.diode_emulation |-> core_mode.phases
        == pms_pkg::PMS_ONE)
        else $error("core diode emulation with several phases");
    AST_AUX_SHAPE: assert property (aux_mode.phases != pms_pkg::PMS_THREE
        && (!aux_mode.diode_emulation || aux_mode.phases == pms_pkg::PMS_ONE))
        else $error("aux mode outside its table");
    AST_BOUNDARY: assert property (core_mode != $past(core_mode)
        && core_mode.phases != pms_pkg::PMS_OFF |-> |cs_hist)
        else $error("core mode moved without a boundary");
    AST_OC_SET: assert property (over_threshold[0] [*4] |=> overcurrent[0])
        else $error("core overcurrent not flagged");
    AST_OC_CLR: assert property (!over_threshold[1] [*4] |=> !overcurrent[1])
        else $error("aux overcurrent stuck");
    AST_SLEW: assert property (core_dac_code > $past(core_dac_code)
        |-> core_dac_code == $past(core_dac_code) + 8'h01)
        else $error("core code rose faster than one step");
    AST_ZC_STEP: assert property (core_zc_threshold != $past(core_zc_threshold)
        |-> core_zc_threshold - $past(core_zc_threshold) inside {6'h01, 6'h3F})
        else $error("threshold moved by more than one");
    // main scenarios reached
    cover property (core_mode.diode_emulation);
    cover property (fb_switch_close);
    cover property ($rose(overcurrent[0]));
endmodule : pms_phase_mode_selector_properties

// ===== pms_stage_model.sv
// Purpose: power stage stand-in for boundaries and diode timing
// Assumes: both outputs switch in step, period of 16 clocks
// Notes: diode time is chosen by the bench per test
`timescale 1ns/100ps
module pms_stage_model (
    input wire logic clock,                       // bench clock
    input wire logic [3:0] dlen,                  // diode time, 8 at most
    output logic [1:0] cycle_start = 2'b00,       // boundary pulse
    output logic [1:0] lowside_off = 2'b00,       // low side released
    output logic [1:0] diode_conducting = 2'b00   // body diode on
);
    logic [3:0] cnt = 4'h0; // place in the switching period
    // stages keep switching through reset, like real hardware
    always_ff @(posedge clock) begin
        cnt <= cnt + 4'h1;
        cycle_start <= {2{cnt < 4'h2}};
        lowside_off <= {2{cnt == 4'h6 || cnt == 4'h7}};
        diode_conducting <= {2{cnt >= 4'h6 && cnt < 4'h6 + dlen}};
    end
endmodule : pms_stage_model

// ===== pms_phase_mode_selector_bench.sv
// Purpose: self-checking bench for the phase mode selector
// Assumes: stage model gives boundaries, bench drives pins and registers
// Notes: slew divider cut to 2 clocks per step to keep ramps short
`timescale 1ns/100ps
module pms_phase_mode_selector_bench;
    localparam int SDIV = 2;                 // short slew divider
    logic clock = 1'b0, rst = 1'b1;          // clock, reset
    pms_pkg::pms_strap_s strap_pins = '0;    // straps and state bits
    logic [1:0] over_threshold = 2'b00, ot;  // comparator levels
    logic [1:0] cs, lo, dc, overcurrent, decaying; // stage and flags
    logic [3:0] dlen = 4'h2;                 // diode time
    logic [7:0] reg_addr = 8'h00, tc;        // address, ramp target
    logic [31:0] reg_wdata = '0, reg_rdata;  // bus data
    logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0; // strobes
    pms_pkg::pms_mode_s core_mode, aux_mode; // applied modes
    logic [7:0] core_dac_code, aux_dac_code; // references
    logic fb_switch_close, fb2_track, irq;   // switch, track, interrupt
    logic [5:0] core_zc_threshold, aux_zc_threshold, zc_low, zc_aux; // thresholds
    logic [6:0] s;                           // strap pattern
    logic [31:0] qm[$], qv[$];               // expected masks, values
    int error_cnt = 0, n_checks = 0;         // counters
    always #5 clock = ~clock;                // 100 MHz
    pms_stage_model stage (.clock(clock), .dlen(dlen), .cycle_start(cs),
        .lowside_off(lo), .diode_conducting(dc));
    pms_phase_mode_selector #(.SLEW_DIV(SDIV)) dut (.clock(clock), .rst(rst),
        .strap_pins(strap_pins), .over_threshold(over_threshold), .cycle_start(cs),
        .lowside_off(lo), .diode_conducting(dc), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .core_mode(core_mode), .aux_mode(aux_mode),
        .overcurrent(overcurrent), .core_dac_code(core_dac_code),
        .aux_dac_code(aux_dac_code), .decaying(decaying),
        .fb_switch_close(fb_switch_close), .fb2_track(fb2_track),
        .core_zc_threshold(core_zc_threshold),
        .aux_zc_threshold(aux_zc_threshold), .irq(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // one strobe cycle, then a quiet edge so no strobe is set twice at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= w;
        reg_read <= !w;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        qm.push_back(m);
        qv.push_back(v);
        bus(1'b0, a, '0);
    endtask : rd
    // expected state word from straps and comparator levels
    function automatic logic [31:0] exp_state(input logic [6:0] p, input logic [1:0] o);
        logic [1:0] cfg, pc, pa;
        cfg = p[6] ? (p[5] ? 2'd1 : 2'd2) : 2'd3;
        pc = p[4] ? 2'd0 : !p[0] ? (!p[1] ? 2'd1 : (cfg == 2'd3 ? 2'd2 : 2'd1)) : cfg;
        pa = p[2] ? 2'd0 : !p[0] ? 2'd1 : (p[3] ? 2'd1 : 2'd2);
        return {21'h0, cfg == 2'd2 && pc == 2'd2, o, 2'b00,
            pa, !p[2] && !p[1] && !p[0], pc, !p[4] && !p[1] && !p[0]};
    endfunction : exp_state
    // watcher: read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_read;
        if (rd_d) check(reg_rdata & qm.pop_front(), qv.pop_front());
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        #200_000;
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h1676));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(pms_pkg::OFS_ZC_THR, 32'hFFF, {20'h0, pms_pkg::THR_RST, pms_pkg::THR_RST});
        rd(pms_pkg::OFS_IRQ_EN, '1, '0);
        rd(8'h1C, '1, '0);
        // every strap and state code except core_phase2_sense without core_phase3_sense, oc level random per step
        for (int i = 0; i < 128; i++) begin
            s = 7'(i);
            s[5] = s[5] & s[6];
            ot = 2'($urandom);
            strap_pins <= s;
            over_threshold <= ot;
            repeat (40) @(posedge clock);
            rd(pms_pkg::OFS_STATE, 32'h73F, exp_state(s, ot));
        end
        // ramp up one step per tick, then jump down
        tc = 8'h20 + 8'($urandom % 32);
        bus(1'b1, pms_pkg::OFS_IRQ_EN, 32'h10);
        bus(1'b1, pms_pkg::OFS_CORE_CODE, {24'h0, tc});
        bus(1'b1, pms_pkg::OFS_AUX_CODE, {24'h0, tc});
        repeat (200) @(posedge clock);
        rd(pms_pkg::OFS_STATE, 32'h07FF_F8C0, {5'h0, tc, tc, 11'h0});
        check({31'h0, irq}, 32'h1);
        bus(1'b1, pms_pkg::OFS_IRQ_EN, '0);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, pms_pkg::OFS_IRQ_CLR, 32'h10);
        bus(1'b1, pms_pkg::OFS_IRQ_EN, 32'h10);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, pms_pkg::OFS_CORE_CODE, {24'h0, tc - 8'h10});
        rd(pms_pkg::OFS_STATE, 32'h07FF_F8C0, {5'h0, tc, tc - 8'h10, 4'h0, 1'b1, 6'h0});
        // long diode time lowers the code, short raises it
        zc_low = core_zc_threshold;
        zc_aux = aux_zc_threshold;
        strap_pins <= '0;
        dlen <= 4'h8;
        repeat (400) @(posedge clock);
        check({30'h0, core_zc_threshold < zc_low, aux_zc_threshold < zc_aux}, 32'h3);
        zc_low = core_zc_threshold;
        dlen <= 4'h1;
        repeat (300) @(posedge clock);
        check({31'h0, core_zc_threshold > zc_low}, 32'h1);
        complete_run();
    end
endmodule : pms_phase_mode_selector_bench
bind pms_phase_mode_selector pms_phase_mode_selector_properties props (.clock(clock),
    .rst(rst), .over_threshold(over_threshold), .cycle_start(cycle_start),
    .core_mode(core_mode), .aux_mode(aux_mode), .overcurrent(overcurrent),
    .core_dac_code(core_dac_code), .fb_switch_close(fb_switch_close),
    .fb2_track(fb2_track), .core_zc_threshold(core_zc_threshold));
